// >>> common/ddsc_params.svh
`ifndef DDSC_PARAMS_SVH
`define DDSC_PARAMS_SVH

// ****************************************
// Command word layout
// ****************************************
`define DDSC_WORD_BITS  16
`define DDSC_CNT_W      5
`define DDSC_SEL_BIT    15
`define DDSC_BUF_BIT    14
`define DDSC_GAIN_BIT   13
`define DDSC_SHUTDOWN_N_BIT   12
`define DDSC_DATA_MSB   11

// ****************************************
// Reset values and default resolution
// ****************************************
`define DDSC_GAIN_N_RST 1'b0
`define DDSC_BUF_RST    1'b0
`define DDSC_SHUTDOWN_N_RST   1'b0
`define DDSC_RES_DEF    12

`endif

// >>> common/ddsc_pkg.sv
package ddsc_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic {
    DDSC_CHAN_A,
    DDSC_CHAN_B
  } ddsc_chan_t;

  typedef enum logic [1:0] {
    DDSC_ST_IDLE,
    DDSC_ST_FRAME,
    DDSC_ST_COMMIT
  } ddsc_state_t;

endpackage : ddsc_pkg

// >>> hdl/ddsc_channel.sv
`timescale 1ns/100ps
`include "ddsc_params.svh"
module ddsc_channel import ddsc_pkg::*; #(
  parameter int RES = `DDSC_RES_DEF
) (
  // Clock and reset
  input  wire logic           clk_in,
  input  wire logic           rst_n_in,
  // Input latch load
  input  wire logic           load_in,
  input  wire logic [RES-1:0] code_in,
  input  wire logic           buf_in,
  input  wire logic           gain_n_in,
  input  wire logic           shutdown_n_n_in,
  // Output latch control
  input  wire logic           transfer_in,
  input  wire logic           hw_off_in,
  input  wire logic           written_in,
  // Channel state
  output logic      [RES-1:0] code_out,
  output logic                buffered_out,
  output logic                gain_select_n_out,
  output logic                output_on_out
);

  logic [RES-1:0] in_code_q;
  logic           in_buf_q;
  logic           in_gain_n_q;
  logic           in_shutdown_n_n_q;
  logic           out_shutdown_n_n_q;

  // ****************************************
  // Input latch
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      in_code_q   <= '0;
      in_buf_q    <= `DDSC_BUF_RST;
      in_gain_n_q <= `DDSC_GAIN_N_RST;
      in_shutdown_n_n_q <= `DDSC_SHUTDOWN_N_RST;
    end else if (load_in) begin
      in_code_q   <= code_in;
      in_buf_q    <= buf_in;
      in_gain_n_q <= gain_n_in;
      in_shutdown_n_n_q <= shutdown_n_n_in;
    end
  end

  // ****************************************
  // Output latch
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      code_out          <= '0;
      buffered_out      <= `DDSC_BUF_RST;
      gain_select_n_out <= `DDSC_GAIN_N_RST;
      out_shutdown_n_n_q      <= `DDSC_SHUTDOWN_N_RST;
    end else if (transfer_in) begin
      code_out          <= in_code_q;
      buffered_out      <= in_buf_q;
      gain_select_n_out <= in_gain_n_q;
      out_shutdown_n_n_q      <= in_shutdown_n_n_q;
    end
  end

  // Pin shutdown overrides the latched bit without disturbing it
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      output_on_out <= 1'b0;
    end else begin
      output_on_out <= out_shutdown_n_n_q & ~hw_off_in & written_in;
    end
  end

endmodule : ddsc_channel

// >>> hdl/ddsc_sync.sv
`timescale 1ns/100ps
module ddsc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // ****************************************
  // Two-stage crossing, first stage read only here
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : ddsc_sync

// >>> hdl/ddsc_top.sv
`timescale 1ns/100ps
`include "ddsc_params.svh"
module ddsc_top import ddsc_pkg::*; #(
  parameter int RES = `DDSC_RES_DEF
) (
  // Core clock and reset
  input  wire logic           clk_in,
  input  wire logic           rst_n_in,
  // Serial link
  input  wire logic           sck_in,
  input  wire logic           cs_n_in,
  input  wire logic           sdi_in,
  // Control pins
  input  wire logic           latch_outputs_n_in,
  input  wire logic           shutdown_n_in,
  // Channel A state
  output logic      [RES-1:0] channel_a_code_out,
  output logic                channel_a_buffered_out,
  output logic                channel_a_gain_select_n_out,
  output logic                channel_a_output_on_out,
  // Channel B state
  output logic      [RES-1:0] channel_b_code_out,
  output logic                channel_b_buffered_out,
  output logic                channel_b_gain_select_n_out,
  output logic                channel_b_output_on_out,
  // Supply monitor control
  output logic                por_monitor_en_out
);

  localparam logic [`DDSC_CNT_W-1:0] LAST_BIT = `DDSC_CNT_W'(`DDSC_WORD_BITS - 1);
  localparam logic [`DDSC_CNT_W-1:0] FULL_CNT = `DDSC_CNT_W'(`DDSC_WORD_BITS);

  // ****************************************
  // Link domain
  // ****************************************
  // Only a data input exists: the link is receive only.
  logic [`DDSC_CNT_W-1:0]     bit_cnt_q;
  logic [`DDSC_WORD_BITS-1:0] shift_q;
  logic [`DDSC_WORD_BITS-1:0] word_q;
  logic                       done_q;

  // Select high clears the count at once, since the serial clock
  // may stand still between frames.
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_cnt_q <= '0;
    end else if (bit_cnt_q != FULL_CNT) begin
      bit_cnt_q <= bit_cnt_q + `DDSC_CNT_W'(1);
    end
  end

  // Rising edges only, so modes 0,0 and 1,1 look alike here
  always_ff @(posedge sck_in) begin
    if (bit_cnt_q != FULL_CNT) begin
      shift_q <= {shift_q[`DDSC_WORD_BITS-2:0], sdi_in};
    end
  end

  // Hold register changes only on a sixteenth edge, so the core may
  // read it freely once the frame-end handshake says it is whole.
  always_ff @(posedge sck_in) begin
    if (bit_cnt_q == LAST_BIT) begin
      word_q <= {shift_q[`DDSC_WORD_BITS-2:0], sdi_in};
    end
  end

  always_ff @(posedge sck_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_q <= 1'b0;
    end else if (bit_cnt_q == LAST_BIT) begin
      done_q <= 1'b1;
    end else if (bit_cnt_q == '0) begin
      done_q <= 1'b0;
    end
  end

  // ****************************************
  // Crossing into the core
  // ****************************************
  logic [3:0] pins_s;
  logic       cs_n_s;
  logic       done_s;
  logic       latch_outputs_n_n_s;
  logic       shutdown_n_n_s;

  // Idle-high pins cross inverted, so the stages' zero reset reads as
  // their idle level and no false shutdown or latch follows reset.
  ddsc_sync #(
    .W (4)
  ) u_sync (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .async_in ({~cs_n_in, done_q, ~latch_outputs_n_in, ~shutdown_n_in}),
    .sync_out (pins_s)
  );

  assign cs_n_s   = ~pins_s[3];
  assign done_s   = pins_s[2];
  assign latch_outputs_n_n_s = ~pins_s[1];
  assign shutdown_n_n_s = ~pins_s[0];

  // ****************************************
  // Frame tracking
  // ****************************************
  ddsc_state_t state_q;
  logic        commit_q;

  // Frame end is judged from select going high; a short frame of one or more
  // clocks clears the done flag and is dropped; one with no clocks recommits the last word.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      state_q <= DDSC_ST_IDLE;
    end else begin
      unique case (state_q)
        DDSC_ST_IDLE: begin
          if (!cs_n_s) begin
            state_q <= DDSC_ST_FRAME;
          end
        end
        DDSC_ST_FRAME: begin
          if (cs_n_s && done_s) begin
            state_q <= DDSC_ST_COMMIT;
          end else if (cs_n_s) begin
            state_q <= DDSC_ST_IDLE;
          end
        end
        DDSC_ST_COMMIT: begin
          state_q <= DDSC_ST_IDLE;
        end
        // Fourth code of the two-bit state is unused
        default: begin
          state_q <= DDSC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      commit_q <= 1'b0;
    end else begin
      commit_q <= (state_q == DDSC_ST_FRAME) && cs_n_s && done_s;
    end
  end

  // ****************************************
  // Command decode
  // ****************************************
  ddsc_chan_t     sel;
  logic [RES-1:0] code;
  logic           load_a;
  logic           load_b;

  assign sel    = word_q[`DDSC_SEL_BIT] ? DDSC_CHAN_B : DDSC_CHAN_A;
  // Left-aligned code; bits below it are ignored
  assign code   = word_q[`DDSC_DATA_MSB -: RES];
  assign load_a = commit_q && (sel == DDSC_CHAN_A);
  assign load_b = commit_q && (sel == DDSC_CHAN_B);

  // ****************************************
  // Power-up gating and latch control
  // ****************************************
  logic written_q;
  logic transfer;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      written_q <= 1'b0;
    end else if (commit_q) begin
      written_q <= 1'b1;
    end
  end

  // Level-sensitive: with the pin tied low the move follows every write
  assign transfer = !latch_outputs_n_n_s;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      por_monitor_en_out <= 1'b1;
    end else begin
      por_monitor_en_out <= shutdown_n_n_s;
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  ddsc_channel #(
    .RES (RES)
  ) u_chan_a (
    .clk_in            (clk_in),
    .rst_n_in          (rst_n_in),
    .load_in           (load_a),
    .code_in           (code),
    .buf_in            (word_q[`DDSC_BUF_BIT]),
    .gain_n_in         (word_q[`DDSC_GAIN_BIT]),
    .shutdown_n_n_in         (word_q[`DDSC_SHUTDOWN_N_BIT]),
    .transfer_in       (transfer),
    .hw_off_in         (!shutdown_n_n_s),
    .written_in        (written_q),
    .code_out          (channel_a_code_out),
    .buffered_out      (channel_a_buffered_out),
    .gain_select_n_out (channel_a_gain_select_n_out),
    .output_on_out     (channel_a_output_on_out)
  );

  ddsc_channel #(
    .RES (RES)
  ) u_chan_b (
    .clk_in            (clk_in),
    .rst_n_in          (rst_n_in),
    .load_in           (load_b),
    .code_in           (code),
    .buf_in            (word_q[`DDSC_BUF_BIT]),
    .gain_n_in         (word_q[`DDSC_GAIN_BIT]),
    .shutdown_n_n_in         (word_q[`DDSC_SHUTDOWN_N_BIT]),
    .transfer_in       (transfer),
    .hw_off_in         (!shutdown_n_n_s),
    .written_in        (written_q),
    .code_out          (channel_b_code_out),
    .buffered_out      (channel_b_buffered_out),
    .gain_select_n_out (channel_b_gain_select_n_out),
    .output_on_out     (channel_b_output_on_out)
  );

endmodule : ddsc_top

// >>> tb/ddsc_host.sv
`timescale 1ns/100ps
module ddsc_host (
  // Serial link to the device
  output logic sck_out,
  output logic cs_n_out,
  output logic sdi_out
);
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
  end

  // ****************************************
  // Write frame
  // ****************************************
  // Clock stands still between frames at the idle level of the chosen mode
  task automatic send(input logic [15:0] word, input int nclk, input bit cpol);
    sck_out = cpol;
    #7 cs_n_out = 1'b0;
    for (int i = 0; i < nclk; i++) begin
      sck_out = 1'b0;
      sdi_out = (i < 16) ? word[15 - i] : i[0];
      #40 sck_out = 1'b1;
      #40;
    end
    sck_out = cpol;
    // Select stays low long enough for the core to see it even with no clocks
    #200 cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #400;
  endtask : send
endmodule : ddsc_host

// >>> tb/ddsc_top_chk.sv
`timescale 1ns/100ps
module ddsc_top_chk #(
  parameter int RES = 12
) (
  // Core clock, reset and pins
  input wire logic           clk_in,
  input wire logic           rst_n_in,
  input wire logic           cs_n_in,
  input wire logic           latch_outputs_n_in,
  input wire logic           shutdown_n_in,
  // Channel state
  input wire logic [RES-1:0] channel_a_code_out,
  input wire logic [RES-1:0] channel_b_code_out,
  input wire logic           channel_a_gain_select_n_out,
  input wire logic           channel_b_gain_select_n_out,
  input wire logic           channel_a_output_on_out,
  input wire logic           channel_b_output_on_out,
  input wire logic           por_monitor_en_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  a_reset_values: assert property ($rose(rst_n_in) |-> channel_a_code_out == '0 &&
    channel_b_code_out == '0 && !channel_a_gain_select_n_out &&
    !channel_b_gain_select_n_out && por_monitor_en_out) else $error("reset state wrong");
  a_reset_off: assert property ($rose(rst_n_in) |->
    (!channel_a_output_on_out && !channel_b_output_on_out) [*3]) else $error("on after reset");
  a_monitor_falls: assert property ($fell(shutdown_n_in) |-> ##[1:4] !por_monitor_en_out)
    else $error("monitor kept on");
  a_monitor_stays: assert property (shutdown_n_in [*5] |-> por_monitor_en_out)
    else $error("monitor off");
  a_pin_forces_off: assert property (!shutdown_n_in [*5] |->
    !channel_a_output_on_out && !channel_b_output_on_out) else $error("on in pin shutdown");
  a_latch_hold: assert property (latch_outputs_n_in [*5] |-> $stable(channel_a_code_out) &&
    $stable(channel_b_code_out) && $stable(channel_a_gain_select_n_out) &&
    $stable(channel_b_gain_select_n_out)) else $error("output moved without latch");
  a_wake_needs_pin: assert property ($rose(channel_a_output_on_out) ||
    $rose(channel_b_output_on_out) |-> por_monitor_en_out) else $error("woke in pin shutdown");
  a_idle_stable: assert property ((cs_n_in && !latch_outputs_n_in) [*8] |->
    $stable(channel_a_code_out) && $stable(channel_b_code_out)) else $error("idle change");
endmodule : ddsc_top_chk

bind ddsc_top ddsc_top_chk #(.RES(RES)) u_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
  .cs_n_in(cs_n_in), .latch_outputs_n_in(latch_outputs_n_in), .shutdown_n_in(shutdown_n_in),
  .channel_a_code_out(channel_a_code_out), .channel_b_code_out(channel_b_code_out),
  .channel_a_gain_select_n_out(channel_a_gain_select_n_out),
  .channel_b_gain_select_n_out(channel_b_gain_select_n_out),
  .channel_a_output_on_out(channel_a_output_on_out),
  .channel_b_output_on_out(channel_b_output_on_out), .por_monitor_en_out(por_monitor_en_out));

// >>> tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  localparam int RES = 12;
  logic           clk_in = 1'b0;
  logic           rst_n_in = 1'b0;
  logic           latch_n = 1'b1;
  logic           shut_n = 1'b1;
  logic           sck, cs_n, sdi;
  logic [RES-1:0] a_code, b_code;
  logic           a_buf, b_buf, a_gain, b_gain, a_on, b_on, por_en;
  int             num_errors = 0;
  int             n_compared = 0;

  always #20 clk_in = ~clk_in;

  ddsc_host u_host (.sck_out(sck), .cs_n_out(cs_n), .sdi_out(sdi));
  ddsc_top #(.RES(RES)) u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .sck_in(sck),
    .cs_n_in(cs_n), .sdi_in(sdi), .latch_outputs_n_in(latch_n), .shutdown_n_in(shut_n),
    .channel_a_code_out(a_code), .channel_a_buffered_out(a_buf),
    .channel_a_gain_select_n_out(a_gain), .channel_a_output_on_out(a_on),
    .channel_b_code_out(b_code), .channel_b_buffered_out(b_buf),
    .channel_b_gain_select_n_out(b_gain), .channel_b_output_on_out(b_on),
    .por_monitor_en_out(por_en));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] st(input bit ch);
    return ch ? {1'b0, b_code, b_buf, b_gain, b_on} : {1'b0, a_code, a_buf, a_gain, a_on};
  endfunction : st

  function automatic logic [15:0] ex(input logic [11:0] code, input logic [2:0] f);
    return {1'b0, code, f};
  endfunction : ex

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Fixed wait covers the commit and output latency of the core
  task automatic wr(input logic [15:0] w, input int n, input bit m);
    u_host.send(w, n, m);
    repeat (4) @(posedge clk_in);
  endtask : wr

  task automatic pins(input logic l, input logic s);
    @(posedge clk_in);
    latch_n <= l;
    shut_n <= s;
    repeat (6) @(posedge clk_in);
  endtask : pins

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    chk(st(0), 16'h0000);
    chk(st(1), 16'h0000);
    chk(16'(por_en), 16'h0001);
    wr(16'h7abc, 16, 1'b0);
    chk(st(0), 16'h0000);
    pins(1'b0, 1'b1);
    chk(st(0), ex(12'habc, 3'b111));
    chk(st(1), 16'h0000);
    wr(16'h95a5, 16, 1'b1);
    chk(st(1), ex(12'h5a5, 3'b001));
    wr(16'h7123, 15, 1'b0);
    chk(st(0), ex(12'habc, 3'b111));
    wr(16'h7fff, 20, 1'b1);
    chk(st(0), ex(12'hfff, 3'b111));
    wr(16'h6123, 16, 1'b0);
    chk(st(0), ex(12'h123, 3'b110));
    chk(st(1), ex(12'h5a5, 3'b001));
    chk(16'(por_en), 16'h0001);
    pins(1'b0, 1'b0);
    chk(16'({a_on, b_on, por_en}), 16'h0000);
    wr(16'h7456, 16, 1'b0);
    chk(16'({a_on, b_on}), 16'h0000);
    pins(1'b0, 1'b1);
    chk(st(0), ex(12'h456, 3'b111));
    chk(st(1), ex(12'h5a5, 3'b001));
    rst_n_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (6) @(posedge clk_in);
    chk(st(0), 16'h0000);
    chk(st(1), 16'h0000);
    chk(16'(por_en), 16'h0001);
    wr(16'h3800, 16, 1'b0);
    chk(st(0), ex(12'h800, 3'b011));
    results();
  end
endmodule : tb_top
